// File: design/srl_pkg.sv
// Purpose: Shared constants and types for the setpoint rate limiter.
// Assumes: 50 MHz clock, values in 0.01 % steps, times in 0.1 s steps.
// Notes: Register offsets are byte addresses on a 32-bit classic bus.
package srl_pkg;
	// ****************************************
	// Timing.
	// ****************************************
	localparam int CLK_HZ = 50_000_000;
	localparam int CTRL_PERIOD_US = 1000;
	localparam int CTRL_CYCLES = CLK_HZ / 1_000_000 * CTRL_PERIOD_US;
	localparam int TICK_W = 20;
	// ****************************************
	// Scaling.
	// ****************************************
	localparam int FRAC_BITS = 16;
	localparam int ACC_W = 36;
	localparam int DIV_W = 40;
	localparam int FULL_SCALE_LSB = 10000;
	localparam int TIME_UNIT_US = 100000;
	localparam int SHAPE_DEN = 20000;
	localparam logic [15:0] SHAPE_GAIN = 16'h0007;
	localparam longint STEP_NUM_INT = 64'(FULL_SCALE_LSB) * CTRL_PERIOD_US * SHAPE_DEN
		/ TIME_UNIT_US;
	localparam logic [DIV_W-1:0] STEP_NUM = DIV_W'(STEP_NUM_INT << FRAC_BITS);
	localparam logic [15:0] TIME_MIN = 16'h0001;
	localparam logic [15:0] TIME_MAX = 16'h1770;
	localparam logic [15:0] PCT_MAX = 16'h2710;
	localparam logic signed [16:0] HYST_LSB = 17'sh00032;
	localparam logic signed [16:0] OUT_LIMIT = 17'sh07530;
	// ****************************************
	// Register map.
	// ****************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_RISE = 8'h04;
	localparam logic [7:0] ADDR_FALL = 8'h08;
	localparam logic [7:0] ADDR_SHAPE = 8'h0C;
	localparam logic [7:0] ADDR_THRESH = 8'h10;
	localparam logic [7:0] ADDR_MIN = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_OUTPUT = 8'h1C;
	localparam int CTRL_FREEZE_BIT = 0;
	localparam int CTRL_INVERT_BIT = 1;
	localparam int CTRL_AUTO_BIT = 2;
	localparam int CTRL_EXT_BIT = 3;
	localparam int CTRL_FIXED_BIT = 4;
	localparam logic [4:0] CTRL_RST = 5'h14;
	localparam logic [15:0] RISE_RST = 16'h0064;
	localparam logic [15:0] FALL_RST = 16'h0064;
	localparam logic [15:0] SHAPE_RST = 16'h00FA;
	localparam logic [15:0] THRESH_RST = 16'h0032;
	localparam logic [15:0] MIN_RST = 16'h0000;
	typedef logic signed [ACC_W-1:0] srl_acc_t;
	typedef struct packed {
		logic [4:0] ctrl;
		logic [15:0] rise;
		logic [15:0] fall;
		logic [15:0] shape;
		logic [15:0] thresh;
		logic [15:0] min_speed;
	} srl_cfg_t;
endpackage : srl_pkg

// File: design/srl_step_div.sv
// Purpose: Serial divider giving the per-cycle step from a transition time.
// Assumes: Divisor is never zero.
// Notes: Restarts forever; a new quotient appears every DIV_W + 1 clocks.
`timescale 1ns/1ns
module srl_step_div import srl_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] den_i,
	output logic [31:0] quot_o
);
	logic [5:0] cnt_ff;
	logic [32:0] rem_ff;
	logic [DIV_W-1:0] quo_ff;
	logic [31:0] den_ff;
	logic [32:0] shifted;
	logic [32:0] trial;
	logic fits;

	assign shifted = {rem_ff[31:0], quo_ff[DIV_W-1]};
	assign trial = shifted - {1'b0, den_ff};
	assign fits = !trial[32];

	// ****************************************
	// Shift and subtract, one bit per clock.
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff <= 6'h00;
			rem_ff <= 33'h0;
			quo_ff <= '0;
			den_ff <= 32'h1;
			quot_o <= 32'h0;
		end else if (cnt_ff == 6'h00) begin
			quot_o <= (quo_ff[DIV_W-1:32] != '0) ? 32'hFFFFFFFF : quo_ff[31:0];
			quo_ff <= STEP_NUM;
			rem_ff <= 33'h0;
			den_ff <= den_i;
			cnt_ff <= 6'(DIV_W);
		end else begin
			rem_ff <= fits ? trial : shifted;
			quo_ff <= {quo_ff[DIV_W-2:0], fits};
			cnt_ff <= cnt_ff - 6'h01;
		end
	end
endmodule : srl_step_div

// File: design/srl_core.sv
// Purpose: Setpoint rate limiter with freeze, resets, minimum clamp and activity flag.
// Assumes: Setpoint, preset and drive enable are synchronous to clk_i.
// Notes: Registers are reached over a classic Wishbone slave.
`timescale 1ns/1ns
module srl_core import srl_pkg::*; #(
	parameter int CTRL_DIV = CTRL_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic signed [15:0] setpoint_i,
	input wire logic signed [15:0] preset_i,
	input wire logic drive_enable_i,
	output logic signed [15:0] rate_out_o,
	output logic active_o
);
	// ****************************************
	// Register file.
	// ****************************************
	srl_cfg_t cfg_ff;
	logic [TICK_W-1:0] tick_cnt_ff;
	logic tick_ff;
	logic en_d_ff;
	logic start_pend_ff;
	logic side_pos_ff;
	srl_acc_t out_ff;
	logic req;
	logic wr;
	logic [31:0] rd_data;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	function automatic logic [15:0] lim_time(input logic [15:0] v);
		lim_time = (v < TIME_MIN) ? TIME_MIN : ((v > TIME_MAX) ? TIME_MAX : v);
	endfunction : lim_time

	function automatic logic [15:0] lim_pct(input logic [15:0] v);
		lim_pct = (v > PCT_MAX) ? PCT_MAX : v;
	endfunction : lim_pct

	assign req = cyc_i && stb_i && !ack_o;
	assign wr = req && we_i;

	logic wr_ctrl;
	logic wr_rise;
	logic wr_fall;
	logic wr_shape;
	logic wr_thresh;
	logic wr_min;
	assign wr_ctrl = wr && adr_i == ADDR_CTRL && sel_i[0];
	assign wr_rise = wr && adr_i == ADDR_RISE;
	assign wr_fall = wr && adr_i == ADDR_FALL;
	assign wr_shape = wr && adr_i == ADDR_SHAPE;
	assign wr_thresh = wr && adr_i == ADDR_THRESH;
	assign wr_min = wr && adr_i == ADDR_MIN;

	srl_cfg_t nxt_cfg;
	assign nxt_cfg.ctrl = wr_ctrl ? dat_i[4:0] : cfg_ff.ctrl;
	assign nxt_cfg.rise = wr_rise ? lim_time(merge16(cfg_ff.rise, dat_i, sel_i))
		: cfg_ff.rise;
	assign nxt_cfg.fall = wr_fall ? lim_time(merge16(cfg_ff.fall, dat_i, sel_i))
		: cfg_ff.fall;
	assign nxt_cfg.shape = wr_shape ? lim_pct(merge16(cfg_ff.shape, dat_i, sel_i))
		: cfg_ff.shape;
	assign nxt_cfg.thresh = wr_thresh ? lim_pct(merge16(cfg_ff.thresh, dat_i, sel_i))
		: cfg_ff.thresh;
	assign nxt_cfg.min_speed = wr_min ? lim_pct(merge16(cfg_ff.min_speed, dat_i, sel_i))
		: cfg_ff.min_speed;

	logic freeze;
	logic invert;
	logic auto_rst;
	logic ext_rst;
	assign freeze = cfg_ff.ctrl[CTRL_FREEZE_BIT];
	assign invert = cfg_ff.ctrl[CTRL_INVERT_BIT];
	assign auto_rst = cfg_ff.ctrl[CTRL_AUTO_BIT];
	assign ext_rst = cfg_ff.ctrl[CTRL_EXT_BIT];

	always_comb begin
		case (adr_i)
			ADDR_CTRL: rd_data = {27'h0, cfg_ff.ctrl};
			ADDR_RISE: rd_data = {16'h0, cfg_ff.rise};
			ADDR_FALL: rd_data = {16'h0, cfg_ff.fall};
			ADDR_SHAPE: rd_data = {16'h0, cfg_ff.shape};
			ADDR_THRESH: rd_data = {16'h0, cfg_ff.thresh};
			ADDR_MIN: rd_data = {16'h0, cfg_ff.min_speed};
			ADDR_STATUS: rd_data = {28'h0, side_pos_ff, start_pend_ff, drive_enable_i, active_o};
			ADDR_OUTPUT: rd_data = {{16{rate_out_o[15]}}, rate_out_o};
			default: rd_data = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_ff <= {CTRL_RST, RISE_RST, FALL_RST, SHAPE_RST, THRESH_RST, MIN_RST};
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			cfg_ff <= nxt_cfg;
			ack_o <= req;
			dat_o <= req ? rd_data : 32'h0;
		end
	end

	// ****************************************
	// Control cycle and start pulse.
	// ****************************************
	logic en_rise;
	logic last_cnt;
	assign en_rise = drive_enable_i && !en_d_ff;
	assign last_cnt = tick_cnt_ff == TICK_W'(CTRL_DIV - 1);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_ff <= '0;
			tick_ff <= 1'b0;
			en_d_ff <= 1'b0;
			start_pend_ff <= 1'b0;
		end else begin
			tick_cnt_ff <= last_cnt ? '0 : tick_cnt_ff + 1'b1;
			tick_ff <= last_cnt;
			en_d_ff <= drive_enable_i;
			start_pend_ff <= en_rise || (start_pend_ff && !tick_ff);
		end
	end

	// ****************************************
	// Step sizes.
	// ****************************************
	logic [31:0] shape_fac;
	logic [31:0] rise_den;
	logic [31:0] fall_den;
	logic [31:0] rise_step;
	logic [31:0] fall_step;
	assign shape_fac = 32'(SHAPE_DEN) + 32'(cfg_ff.shape) * 32'(SHAPE_GAIN);
	assign rise_den = 32'(cfg_ff.rise) * shape_fac;
	assign fall_den = 32'(cfg_ff.fall) * shape_fac;

	srl_step_div u_rise_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.den_i(rise_den),
		.quot_o(rise_step)
	);

	srl_step_div u_fall_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.den_i(fall_den),
		.quot_o(fall_step)
	);

	// ****************************************
	// Setpoint conditioning.
	// ****************************************
	logic signed [16:0] sp_ext;
	logic signed [16:0] sp_inv;
	logic signed [16:0] sp_mag;
	logic signed [16:0] min_s;
	logic clamp_on;
	logic signed [16:0] sp_min;
	logic signed [16:0] cond;
	logic nxt_side_pos;
	assign sp_ext = 17'(setpoint_i);
	assign sp_inv = invert ? -sp_ext : sp_ext;
	assign sp_mag = sp_inv[16] ? -sp_inv : sp_inv;
	assign min_s = {1'b0, cfg_ff.min_speed};
	assign nxt_side_pos = (sp_inv > HYST_LSB) ? 1'b1 : ((sp_inv < -HYST_LSB) ? 1'b0 : side_pos_ff);
	assign clamp_on = drive_enable_i && cfg_ff.min_speed != 16'h0 && sp_mag < min_s;
	assign sp_min = clamp_on ? (nxt_side_pos ? min_s : -min_s) : sp_inv;
	assign cond = (sp_min > OUT_LIMIT) ? OUT_LIMIT : ((sp_min < -OUT_LIMIT) ? -OUT_LIMIT : sp_min);

	// ****************************************
	// Rate limiting.
	// ****************************************
	srl_acc_t target;
	srl_acc_t preset_acc;
	srl_acc_t diff;
	srl_acc_t abs_diff;
	srl_acc_t step_sel;
	srl_acc_t tracked;
	srl_acc_t nxt_out;
	logic away;
	logic reset_now;
	assign target = srl_acc_t'(cond) <<< FRAC_BITS;
	assign preset_acc = srl_acc_t'(preset_i) <<< FRAC_BITS;
	assign diff = target - out_ff;
	assign abs_diff = diff[ACC_W-1] ? -diff : diff;
	assign away = (!out_ff[ACC_W-1] && !diff[ACC_W-1]) || (out_ff <= 0 && diff[ACC_W-1]);
	assign step_sel = away ? srl_acc_t'({4'h0, rise_step}) : srl_acc_t'({4'h0, fall_step});
	assign tracked = (abs_diff <= step_sel) ? target
		: (diff[ACC_W-1] ? out_ff - step_sel : out_ff + step_sel);
	assign reset_now = ext_rst || (auto_rst && start_pend_ff);
	assign nxt_out = reset_now ? preset_acc : (freeze ? out_ff : tracked);

	// ****************************************
	// Activity flag.
	// ****************************************
	logic signed [16:0] out_int;
	logic signed [16:0] act_diff;
	logic signed [16:0] act_mag;
	logic nxt_active;
	assign out_int = 17'(rate_out_o);
	assign act_diff = out_int - cond;
	assign act_mag = act_diff[16] ? -act_diff : act_diff;
	assign nxt_active = act_mag > {1'b0, cfg_ff.thresh};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_ff <= '0;
			side_pos_ff <= 1'b1;
			active_o <= 1'b0;
		end else begin
			out_ff <= tick_ff ? nxt_out : out_ff;
			side_pos_ff <= nxt_side_pos;
			active_o <= nxt_active;
		end
	end

	assign rate_out_o = out_ff[FRAC_BITS+15:FRAC_BITS];

	// ****************************************
	// Assertions.
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	hold_no_tick_a: assert property (!tick_ff |=> $stable(out_ff))
		else $error("Output moved outside a control cycle.");
	freeze_hold_a: assert property (tick_ff && freeze && !reset_now
		|=> out_ff == $past(out_ff))
		else $error("Freeze did not hold the output.");
	ext_reset_a: assert property (tick_ff && ext_rst |=> rate_out_o == $past(preset_i))
		else $error("External reset did not load the preset.");
	auto_reset_a: assert property (tick_ff && auto_rst && start_pend_ff
		|=> rate_out_o == $past(preset_i))
		else $error("Start reset did not load the preset.");
	start_set_a: assert property (en_rise |=> start_pend_ff)
		else $error("Drive start did not raise the start pulse.");
	start_quiet_a: assert property (!start_pend_ff && !en_rise |=> !start_pend_ff)
		else $error("Start pulse raised without a drive start.");
	start_once_a: assert property (tick_ff && !en_rise |=> !start_pend_ff)
		else $error("Start pulse lasted past one control cycle.");
	step_bound_a: assert property (tick_ff && !reset_now && !freeze
		|=> ((out_ff - $past(out_ff)) <= $past(step_sel))
		&& (($past(out_ff) - out_ff) <= $past(step_sel)))
		else $error("Output moved more than one step.");
	min_clamp_a: assert property (drive_enable_i && cfg_ff.min_speed != 16'h0
		|-> (cond >= min_s) || (cond <= -min_s))
		else $error("Conditioned setpoint fell inside the minimum.");
	activity_a: assert property ((rate_out_o - cond > $signed({1'b0, cfg_ff.thresh}))
		|| (cond - rate_out_o > $signed({1'b0, cfg_ff.thresh})) |=> active_o)
		else $error("Activity flag missed a large gap.");
	tick_gap_a: assert property (tick_ff |=> !tick_ff)
		else $error("Control cycle pulse lasted two clocks.");

	freeze_c: cover property (tick_ff && freeze && !reset_now);
	ext_reset_c: cover property (tick_ff && ext_rst);
	start_reset_c: cover property (tick_ff && auto_rst && start_pend_ff);
	min_clamp_c: cover property (tick_ff && clamp_on);
endmodule : srl_core

// File: verification/srl_far_model.sv
// Purpose: Far-side model: drive sequencing and speed feedback.
// Assumes: Speed feedback equals the limited output one clock late.
// Notes: The preset follows the feedback while fb_sel_i is set.
`timescale 1ns/1ns
module srl_far_model import srl_pkg::*; (
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic fb_sel_i,
	input wire logic signed [15:0] fixed_i,
	input wire logic signed [15:0] rate_out_i,
	output logic drive_enable_o = 1'b0,
	output logic signed [15:0] preset_o = 16'sh0000
);
	// ********
	// Sequencing and feedback.
	// ********
	logic signed [15:0] speed_fb_ff = 16'sh0000;
	always @(posedge clk_i) begin
		speed_fb_ff <= rate_out_i;
		drive_enable_o <= run_i;
		preset_o <= fb_sel_i ? speed_fb_ff : fixed_i;
	end
endmodule : srl_far_model

// File: verification/setpoint_rate_limiter_tb.sv
// Purpose: Self-checking bench for the setpoint rate limiter.
// Assumes: Control cycle shortened to 20 clocks; rise 1 gives 100 and fall 2 gives 50 per cycle.
// Notes: Moves are measured over whole control cycles, so the tick phase drops out.
`timescale 1ns/1ns
module setpoint_rate_limiter_tb import srl_pkg::*;;
	localparam int DIV = 20;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic signed [15:0] setpoint_i = 16'sh0000;
	logic [31:0] dat_o;
	logic ack_o;
	logic signed [15:0] preset_i;
	logic drive_enable_i;
	logic signed [15:0] rate_out_o;
	logic active_o;
	logic run = 1'b0;
	logic fb_sel = 1'b0;
	logic signed [15:0] fixed = 16'sh0000;
	int n_fail = 0;
	int total_checks = 0;
	int cycles = 0;
	always #10 clk_i = ~clk_i;
	srl_core #(.CTRL_DIV(DIV)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .setpoint_i(setpoint_i), .preset_i(preset_i),
		.drive_enable_i(drive_enable_i), .rate_out_o(rate_out_o), .active_o(active_o));
	srl_far_model i_far (.clk_i(clk_i), .run_i(run), .fb_sel_i(fb_sel), .fixed_i(fixed),
		.rate_out_i(rate_out_o), .drive_enable_o(drive_enable_i), .preset_o(preset_i));
	// ********
	// Common tasks.
	// ********
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	task automatic chk(input string what, input logic signed [31:0] seen,
		input logic signed [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %0d seen %0d", what, exp, seen);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= wr;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'h3;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		chk("bus answer", n, 2);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk($sformatf("reg %h", a), q, e);
	endtask : rd
	task automatic ticks(input int n);
		repeat (n * DIV) @(posedge clk_i);
	endtask : ticks
	task automatic rate(input string what, input int n, input logic signed [31:0] e);
		logic signed [31:0] a;
		ticks(1);
		a = rate_out_o;
		ticks(n);
		chk(what, rate_out_o - a, e);
	endtask : rate
	task automatic load(input logic signed [15:0] v, input logic [31:0] keep);
		fixed <= v;
		wr(ADDR_CTRL, keep | 32'h8);
		ticks(4);
		wr(ADDR_CTRL, keep);
	endtask : load
	// ********
	// Scenarios.
	// ********
	task automatic t_regs;
		rd(ADDR_CTRL, {27'h0, CTRL_RST});
		rd(ADDR_RISE, {16'h0, RISE_RST});
		rd(ADDR_FALL, {16'h0, FALL_RST});
		rd(ADDR_SHAPE, {16'h0, SHAPE_RST});
		rd(ADDR_THRESH, {16'h0, THRESH_RST});
		rd(ADDR_MIN, {16'h0, MIN_RST});
		wr(ADDR_RISE, 32'h0000FFFF);
		rd(ADDR_RISE, {16'h0, TIME_MAX});
		wr(ADDR_OUTPUT, 32'h00000055);
		rd(ADDR_OUTPUT, 32'h0);
		rd(8'h20, 32'h0);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_track;
		wr(ADDR_RISE, 32'h1);
		wr(ADDR_FALL, 32'h2);
		wr(ADDR_SHAPE, 32'h0);
		load(16'sh0000, 32'h0);
		setpoint_i <= 16'sh0BB8;
		rate("rise step", 10, 32'sh3E8);
		ticks(30);
		chk("at target", rate_out_o, 32'shBB8);
		setpoint_i <= 16'sh03E8;
		rate("fall step", 10, -32'sh1F4);
		wr(ADDR_CTRL, 32'h2);
		ticks(70);
		chk("inverted", rate_out_o, -32'sh3E8);
		$display("t_track done");
	endtask : t_track
	task automatic t_hold;
		wr(ADDR_CTRL, 32'h3);
		setpoint_i <= 16'sh0000;
		ticks(10);
		chk("held", rate_out_o, -32'sh3E8);
		wr(ADDR_CTRL, 32'h2);
		rate("resume", 4, 32'shC8);
		fixed <= 16'sh02BC;
		wr(ADDR_CTRL, 32'hB);
		ticks(3);
		chk("reset over hold", rate_out_o, 32'sh2BC);
		wr(ADDR_CTRL, 32'h1);
		setpoint_i <= 16'sh07D0;
		ticks(3);
		chk("held after reset", rate_out_o, 32'sh2BC);
		wr(ADDR_CTRL, 32'h0);
		rate("tracks again", 5, 32'sh1F4);
		$display("t_hold done");
	endtask : t_hold
	task automatic t_shape;
		setpoint_i <= 16'sh0000;
		wr(ADDR_SHAPE, 32'h720);
		load(16'sh0000, 32'h0);
		setpoint_i <= 16'sh1388;
		// Effective time 163.84 cycles per full scale: 16 cycles move 976.
		rate("shaped step", 16, 32'sh3D0);
		wr(ADDR_SHAPE, 32'h0);
		$display("t_shape done");
	endtask : t_shape
	task automatic t_min;
		run <= 1'b1;
		setpoint_i <= 16'sh0000;
		wr(ADDR_MIN, 32'h3E8);
		load(16'sh00C8, 32'h0);
		chk("preset below min", rate_out_o, 32'shC8);
		rate("up to min", 5, 32'sh1F4);
		ticks(10);
		chk("at min", rate_out_o, 32'sh3E8);
		setpoint_i <= -16'sh0064;
		rate("through zero", 10, -32'sh1F4);
		ticks(40);
		chk("negative min", rate_out_o, -32'sh3E8);
		rd(ADDR_STATUS, 32'h2);
		rd(ADDR_OUTPUT, 32'hFFFFFC18);
		setpoint_i <= 16'sh001E;
		ticks(10);
		chk("hysteresis", rate_out_o, -32'sh3E8);
		setpoint_i <= 16'sh003C;
		ticks(40);
		chk("positive min", rate_out_o, 32'sh3E8);
		run <= 1'b0;
		setpoint_i <= 16'sh0000;
		ticks(25);
		chk("min off", rate_out_o, 32'sh0);
		wr(ADDR_MIN, 32'h0);
		$display("t_min done");
	endtask : t_min
	task automatic t_start;
		fixed <= 16'sh04D2;
		wr(ADDR_CTRL, 32'h5);
		run <= 1'b1;
		ticks(3);
		chk("start load", rate_out_o, 32'sh4D2);
		fixed <= 16'sh01F4;
		run <= 1'b0;
		ticks(3);
		chk("no load at stop", rate_out_o, 32'sh4D2);
		wr(ADDR_CTRL, 32'h1);
		run <= 1'b1;
		ticks(3);
		chk("option off", rate_out_o, 32'sh4D2);
		fb_sel <= 1'b1;
		run <= 1'b0;
		setpoint_i <= 16'sh0BB8;
		wr(ADDR_CTRL, 32'h4);
		run <= 1'b1;
		ticks(2);
		rate("pickup", 5, 32'sh1F4);
		fb_sel <= 1'b0;
		run <= 1'b0;
		$display("t_start done");
	endtask : t_start
	task automatic t_active;
		setpoint_i <= 16'sh0000;
		load(16'sh0000, 32'h0);
		setpoint_i <= 16'sh07D0;
		ticks(2);
		chk("moving flag", active_o, 1);
		ticks(25);
		chk("settled flag", active_o, 0);
		wr(ADDR_THRESH, 32'h2710);
		setpoint_i <= -16'sh07D0;
		ticks(2);
		chk("under threshold", active_o, 0);
		$display("t_active done");
	endtask : t_active
	// ********
	// Main sequence and timeout.
	// ********
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_track();
		t_hold();
		t_shape();
		t_min();
		t_start();
		t_active();
		results();
	end
endmodule : setpoint_rate_limiter_tb
